// ==== verilog/ipr_pkg.sv ====
package ipr_pkg;

  localparam int unsigned NUM_SRC   = 19;
  localparam int unsigned NUM_REG   = 5;
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned LVL_W     = 3;
  localparam int unsigned SRC_W     = 5;

  // register offsets on the plain register port
  localparam logic [3:0] PRIO9_OFS  = 4'h0;
  localparam logic [3:0] PRIO10_OFS = 4'h1;
  localparam logic [3:0] PRIO11_OFS = 4'h2;
  localparam logic [3:0] PRIO12_OFS = 4'h3;
  localparam logic [3:0] PRIO13_OFS = 4'h4;
  localparam logic [3:0] REG_OFS [0:NUM_REG-1] = '{PRIO9_OFS, PRIO10_OFS, PRIO11_OFS, PRIO12_OFS, PRIO13_OFS};

  // implemented bits per register; the rest read zero
  localparam logic [15:0] MASK_FULL  = 16'h7777;
  localparam logic [15:0] MASK_PRIO11 = 16'h7707;
  localparam logic [15:0] REG_MASK [0:NUM_REG-1] = '{MASK_FULL, MASK_FULL, MASK_PRIO11, MASK_FULL, MASK_FULL};

  // field positions inside a register
  localparam logic [3:0] POS_LO   = 4'h0;
  localparam logic [3:0] POS_ML   = 4'h4;
  localparam logic [3:0] POS_MH   = 4'h8;
  localparam logic [3:0] POS_HI   = 4'hC;

  // level codes
  localparam logic [2:0] LEVEL_OFF   = 3'h0;
  localparam logic [2:0] LEVEL_MIN   = 3'h1;
  localparam logic [2:0] LEVEL_MAX   = 3'h7;
  localparam logic [2:0] LEVEL_RESET = 3'h4;

  // source numbering, also the tie order: lower number wins
  localparam logic [4:0] SRC_XFER3_DONE   = 5'h00;
  localparam logic [4:0] SRC_CAPTURE3     = 5'h01;
  localparam logic [4:0] SRC_CAPTURE4     = 5'h02;
  localparam logic [4:0] SRC_CAPTURE5     = 5'h03;
  localparam logic [4:0] SRC_CAPTURE6     = 5'h04;
  localparam logic [4:0] SRC_COMPARE5     = 5'h05;
  localparam logic [4:0] SRC_COMPARE6     = 5'h06;
  localparam logic [4:0] SRC_COMPARE7     = 5'h07;
  localparam logic [4:0] SRC_COMPARE8     = 5'h08;
  localparam logic [4:0] SRC_XFER4_DONE   = 5'h09;
  localparam logic [4:0] SRC_TIMER6       = 5'h0A;
  localparam logic [4:0] SRC_TIMER7       = 5'h0B;
  localparam logic [4:0] SRC_I2C_B_SLAVE  = 5'h0C;
  localparam logic [4:0] SRC_I2C_B_MASTER = 5'h0D;
  localparam logic [4:0] SRC_TIMER8       = 5'h0E;
  localparam logic [4:0] SRC_TIMER9       = 5'h0F;
  localparam logic [4:0] SRC_EXT_IRQ3     = 5'h10;
  localparam logic [4:0] SRC_EXT_IRQ4     = 5'h11;
  localparam logic [4:0] SRC_CAN_B_RX     = 5'h12;

  // per source: owning register index and low bit of its field
  localparam logic [2:0] FIELD_REG [0:NUM_SRC-1] = '{
    3'h0, 3'h0, 3'h0, 3'h0,
    3'h1, 3'h1, 3'h1, 3'h1,
    3'h2, 3'h2, 3'h2,
    3'h3, 3'h3, 3'h3, 3'h3,
    3'h4, 3'h4, 3'h4, 3'h4};
  localparam logic [3:0] FIELD_POS [0:NUM_SRC-1] = '{
    POS_LO, POS_ML, POS_MH, POS_HI,
    POS_LO, POS_ML, POS_MH, POS_HI,
    POS_LO, POS_MH, POS_HI,
    POS_LO, POS_ML, POS_MH, POS_HI,
    POS_LO, POS_ML, POS_MH, POS_HI};

  typedef logic [NUM_SRC-1:0][LVL_W-1:0] ipr_levels_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ipr_bus_req_s;

  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] source;
    logic [LVL_W-1:0] level;
  } ipr_grant_s;

endpackage

// ==== verilog/ipr_arbiter.sv ====
`timescale 1ns/100ps

module ipr_arbiter
  import ipr_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] elig_in,
  input  wire ipr_levels_t        levels_in,
  output logic                    valid_out,
  output logic [SRC_W-1:0]        source_out,
  output logic [LVL_W-1:0]        level_out
);

  // strict compare while walking upward keeps the lower source on a tie
  always_comb begin
    valid_out  = 1'b0;
    source_out = '0;
    level_out  = LEVEL_OFF;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (elig_in[i] && (levels_in[i] > level_out)) begin // [R14]
        valid_out  = 1'b1;
        source_out = SRC_W'(i);
        level_out  = levels_in[i];
      end
    end
  end

endmodule // ipr_arbiter

// ==== verilog/ipr_regs.sv ====
`timescale 1ns/100ps

// Operation
// [R1] three-bit field, code 111 is level 7
// [R2] code 001 is level 1, binary levels
// [R3] code 000 never forwards its source
// [R4] every field resets to code 100
// [R5] unimplemented bits read zero, ignore writes
// [R6] bits 15, 11, 7, 3 are separators
// [R7] register 9: capture5, capture4, capture3, xfer3
// [R8] register 10: compare7, compare6, compare5, capture6
// [R9] register 11: timer6, xfer4, compare8; 7-3 empty
// [R10] register 12: timer8, i2c master, slave, timer7
// [R11] register 13: can rx, ext4, ext3, timer9
// [R12] all sources level 4 after reset
// [R13] software: level, clear flag, then enable
// [R14] highest eligible level wins, lower source ties
module ipr_regs
  import ipr_pkg::*;
(
  input  wire logic               sys_clk_in,
  input  wire logic               rstn_in,
  input  wire ipr_bus_req_s       bus_req_in,
  output logic [DATA_W-1:0]       rd_data_out,
  input  wire logic [NUM_SRC-1:0] pending_flag_regs_in,
  input  wire logic [NUM_SRC-1:0] source_enable_regs_in,
  output ipr_grant_s              grant_out,
  output ipr_levels_t             levels_out
);

  ipr_levels_t              levels_reg;
  logic [NUM_SRC-1:0]       elig;
  logic [DATA_W-1:0]        words [0:NUM_REG-1];
  logic [DATA_W-1:0]        rd_next;
  logic [DATA_W-1:0]        rd_data_reg;
  ipr_grant_s               grant_reg;
  ipr_grant_s               grant_next;
  logic                     first_cycle_reg;

  // field storage and eligibility, one slice per source
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_field
      always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          levels_reg[g] <= LEVEL_RESET; // [R4] [R12]
        end else if (bus_req_in.wr && (bus_req_in.addr == REG_OFS[FIELD_REG[g]])) begin
          levels_reg[g] <= bus_req_in.wdata[FIELD_POS[g] +: LVL_W]; // [R1] [R2] [R7] [R8] [R9] [R10] [R11]
        end
      end
      // level zero masks the source regardless of flag and enable
      assign elig[g] = pending_flag_regs_in[g] && source_enable_regs_in[g] && (levels_reg[g] != LEVEL_OFF); // [R3]
    end
  endgenerate

  // readback assembly; separator bits are never filled
  always_comb begin
    for (int k = 0; k < NUM_REG; k++) begin
      words[k] = '0;
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      words[FIELD_REG[i]][FIELD_POS[i] +: LVL_W] = levels_reg[i]; // [R6]
    end
  end

  // unmapped offsets read zero
  always_comb begin
    rd_next = '0;
    for (int k = 0; k < NUM_REG; k++) begin
      if (bus_req_in.addr == REG_OFS[k]) begin
        rd_next = words[k] & REG_MASK[k]; // [R5]
      end
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_reg <= '0;
    end else if (bus_req_in.rd) begin
      rd_data_reg <= rd_next;
    end else begin
      rd_data_reg <= '0;
    end
  end

  ipr_arbiter u_arbiter (
    .elig_in    (elig),
    .levels_in  (levels_reg),
    .valid_out  (grant_next.valid),
    .source_out (grant_next.source),
    .level_out  (grant_next.level)
  );

  // registered grant costs one cycle of latency but gives clean outputs to the core
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      grant_reg <= '0;
    end else begin
      grant_reg <= grant_next; // [R14]
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      first_cycle_reg <= 1'b1;
    end else begin
      first_cycle_reg <= 1'b0;
    end
  end

  assign rd_data_out = rd_data_reg;
  assign grant_out   = grant_reg;
  assign levels_out  = levels_reg;

  // checking helpers
  logic [NUM_SRC-1:0] beaten;
  logic [NUM_SRC-1:0] tie_lost;
  logic [LVL_W-1:0]   grant_src_level;
  logic [DATA_W-1:0]  rd_mask_exp;

  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_check
      assign beaten[g]   = elig[g] && (levels_reg[g] > grant_next.level);
      assign tie_lost[g] = elig[g] && (levels_reg[g] == grant_next.level) && (SRC_W'(g) < grant_next.source);
    end
  endgenerate

  always_comb begin
    grant_src_level = LEVEL_OFF;
    rd_mask_exp     = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (grant_next.source == SRC_W'(i)) begin
        grant_src_level = levels_reg[i];
      end
    end
    for (int k = 0; k < NUM_REG; k++) begin
      if (bus_req_in.addr == REG_OFS[k]) begin
        rd_mask_exp = REG_MASK[k];
      end
    end
  end

  max_code_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO9_OFS && bus_req_in.wdata[14:12] == LEVEL_MAX)
    |=> levels_reg[SRC_CAPTURE5] == LEVEL_MAX) // [R1]
    else $error("code 111 not stored as level 7");

  min_code_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO13_OFS && bus_req_in.wdata[2:0] == LEVEL_MIN)
    ##1 (bus_req_in.rd && bus_req_in.addr == PRIO13_OFS) |=> rd_data_out[2:0] == LEVEL_MIN) // [R2]
    else $error("code 001 not read back as level 1");

  disabled_no_fwd_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    grant_next.valid |-> (grant_src_level != LEVEL_OFF) && (grant_next.level == grant_src_level)
    && elig[grant_next.source]) // [R3]
    else $error("disabled or ineligible source forwarded");

  grant_valid_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    ##1 (grant_out.valid == ($past(elig) != '0))) // [R3]
    else $error("grant valid does not follow eligibility");

  reset_level_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    first_cycle_reg |-> (words[0] == 16'h4444) && (words[1] == 16'h4444) && (words[2] == 16'h4404)
    && (words[3] == 16'h4444) && (words[4] == 16'h4444)) // [R4] [R12]
    else $error("fields not at level 4 after reset");

  unimpl_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    bus_req_in.rd |=> (rd_data_out & ~$past(rd_mask_exp)) == 16'h0000) // [R5] [R6]
    else $error("unimplemented bit read nonzero");

  readback_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO11_OFS) ##1 (bus_req_in.rd && bus_req_in.addr == PRIO11_OFS)
    |=> rd_data_out == ($past(bus_req_in.wdata, 2) & MASK_PRIO11)) // [R5] [R9]
    else $error("register 11 readback differs from masked write");

  read_one_cycle_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !bus_req_in.rd |=> rd_data_out == 16'h0000) // [R5]
    else $error("read data outside its cycle");

  layout9_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO9_OFS) |=>
    levels_reg[SRC_CAPTURE5] == $past(bus_req_in.wdata[14:12]) && levels_reg[SRC_CAPTURE4] == $past(bus_req_in.wdata[10:8])
    && levels_reg[SRC_CAPTURE3] == $past(bus_req_in.wdata[6:4])
    && levels_reg[SRC_XFER3_DONE] == $past(bus_req_in.wdata[2:0])) // [R7]
    else $error("register 9 field layout wrong");

  layout10_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO10_OFS) |=>
    levels_reg[SRC_COMPARE7] == $past(bus_req_in.wdata[14:12]) && levels_reg[SRC_COMPARE6] == $past(bus_req_in.wdata[10:8])
    && levels_reg[SRC_COMPARE5] == $past(bus_req_in.wdata[6:4])
    && levels_reg[SRC_CAPTURE6] == $past(bus_req_in.wdata[2:0])) // [R8]
    else $error("register 10 field layout wrong");

  layout11_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO11_OFS) |=>
    levels_reg[SRC_TIMER6] == $past(bus_req_in.wdata[14:12]) && levels_reg[SRC_XFER4_DONE] == $past(bus_req_in.wdata[10:8])
    && levels_reg[SRC_COMPARE8] == $past(bus_req_in.wdata[2:0])) // [R9]
    else $error("register 11 field layout wrong");

  layout12_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO12_OFS) |=>
    levels_reg[SRC_TIMER8] == $past(bus_req_in.wdata[14:12])
    && levels_reg[SRC_I2C_B_MASTER] == $past(bus_req_in.wdata[10:8])
    && levels_reg[SRC_I2C_B_SLAVE] == $past(bus_req_in.wdata[6:4])
    && levels_reg[SRC_TIMER7] == $past(bus_req_in.wdata[2:0])) // [R10]
    else $error("register 12 field layout wrong");

  layout13_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO13_OFS) |=>
    levels_reg[SRC_CAN_B_RX] == $past(bus_req_in.wdata[14:12]) && levels_reg[SRC_EXT_IRQ4] == $past(bus_req_in.wdata[10:8])
    && levels_reg[SRC_EXT_IRQ3] == $past(bus_req_in.wdata[6:4])
    && levels_reg[SRC_TIMER9] == $past(bus_req_in.wdata[2:0])) // [R11]
    else $error("register 13 field layout wrong");

  highest_wins_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    beaten == '0) // [R14]
    else $error("higher eligible level not granted");

  tie_order_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    grant_next.valid |-> tie_lost == '0) // [R14]
    else $error("tie not resolved toward lower source");

  grant_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    grant_next.valid |=> grant_out.source == $past(grant_next.source) && grant_out.level == $past(grant_next.level)) // [R14]
    else $error("grant register did not capture the winner");

  reset_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    first_cycle_reg |-> (grant_out == '0) && (rd_data_out == 16'h0000)) // [R4]
    else $error("outputs not idle after reset");

  unmapped_read_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.rd && bus_req_in.addr > PRIO13_OFS) |=> rd_data_out == 16'h0000) // [R5]
    else $error("unmapped offset read nonzero");

  unmapped_write_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr > PRIO13_OFS) |=> levels_reg == $past(levels_reg)) // [R5]
    else $error("unmapped write changed a level");

  sep_bits_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    bus_req_in.rd |=> (rd_data_out & 16'h8888) == 16'h0000) // [R6]
    else $error("separator bit read nonzero");

  reg11_gap_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.rd && bus_req_in.addr == PRIO11_OFS) |=> rd_data_out[7:3] == 5'h00) // [R9]
    else $error("register 11 empty span read nonzero");

  // readback layout is checked against the stored levels, not the assembled words
  reg9_read_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.rd && bus_req_in.addr == PRIO9_OFS) |=>
    rd_data_out == {1'b0, $past(levels_reg[SRC_CAPTURE5]), 1'b0, $past(levels_reg[SRC_CAPTURE4]),
    1'b0, $past(levels_reg[SRC_CAPTURE3]), 1'b0, $past(levels_reg[SRC_XFER3_DONE])}) // [R7]
    else $error("register 9 readback layout wrong");

  reg10_read_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.rd && bus_req_in.addr == PRIO10_OFS) |=>
    rd_data_out == {1'b0, $past(levels_reg[SRC_COMPARE7]), 1'b0, $past(levels_reg[SRC_COMPARE6]),
    1'b0, $past(levels_reg[SRC_COMPARE5]), 1'b0, $past(levels_reg[SRC_CAPTURE6])}) // [R8]
    else $error("register 10 readback layout wrong");

  reg11_read_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.rd && bus_req_in.addr == PRIO11_OFS) |=>
    rd_data_out == {1'b0, $past(levels_reg[SRC_TIMER6]), 1'b0, $past(levels_reg[SRC_XFER4_DONE]),
    5'h00, $past(levels_reg[SRC_COMPARE8])}) // [R9]
    else $error("register 11 readback layout wrong");

  reg12_read_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.rd && bus_req_in.addr == PRIO12_OFS) |=>
    rd_data_out == {1'b0, $past(levels_reg[SRC_TIMER8]), 1'b0, $past(levels_reg[SRC_I2C_B_MASTER]),
    1'b0, $past(levels_reg[SRC_I2C_B_SLAVE]), 1'b0, $past(levels_reg[SRC_TIMER7])}) // [R10]
    else $error("register 12 readback layout wrong");

  reg13_read_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.rd && bus_req_in.addr == PRIO13_OFS) |=>
    rd_data_out == {1'b0, $past(levels_reg[SRC_CAN_B_RX]), 1'b0, $past(levels_reg[SRC_EXT_IRQ4]),
    1'b0, $past(levels_reg[SRC_EXT_IRQ3]), 1'b0, $past(levels_reg[SRC_TIMER9])}) // [R11]
    else $error("register 13 readback layout wrong");

  zero_no_grant_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    grant_out.valid |-> grant_out.level != LEVEL_OFF) // [R3]
    else $error("grant carries level zero");

  max_level_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (elig[SRC_CAPTURE5] && levels_reg[SRC_CAPTURE5] == LEVEL_MAX)
    |=> grant_out.valid && grant_out.level == LEVEL_MAX) // [R1]
    else $error("eligible level 7 source not at top");

  min_level_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (elig[SRC_TIMER9] && elig[SRC_EXT_IRQ3] && levels_reg[SRC_TIMER9] == LEVEL_MIN
    && levels_reg[SRC_EXT_IRQ3] > LEVEL_MIN) |=> grant_out.source != SRC_TIMER9) // [R2]
    else $error("level 1 source beat a higher one");

  off_source_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    levels_reg[SRC_XFER3_DONE] == LEVEL_OFF
    |=> !(grant_out.valid && grant_out.source == SRC_XFER3_DONE)) // [R3]
    else $error("source at code 000 was forwarded");

  elig_grant_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (elig != '0) |=> grant_out.valid) // [R14]
    else $error("eligible request not forwarded");

  write_scope_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (bus_req_in.wr && bus_req_in.addr == PRIO9_OFS) |=>
    levels_reg[SRC_CAPTURE6] == $past(levels_reg[SRC_CAPTURE6])
    && levels_reg[SRC_TIMER9] == $past(levels_reg[SRC_TIMER9])) // [R7]
    else $error("register 9 write reached another register");

endmodule // ipr_regs

// ==== tb/ipr_cpu_model.sv ====
`timescale 1ns/100ps

module ipr_cpu_model
  import ipr_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire ipr_grant_s  grant_in,
  output logic [SRC_W-1:0] taken_src_out,
  output logic [LVL_W-1:0] taken_lvl_out
);
  // core takes every forwarded request at once; no nesting modelled
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      taken_src_out <= '1;
      taken_lvl_out <= '0;
    end else if (grant_in.valid) begin
      taken_src_out <= grant_in.source;
      taken_lvl_out <= grant_in.level;
    end
  end
endmodule // ipr_cpu_model

// ==== tb/ipr_regs_test.sv ====
`timescale 1ns/100ps

module ipr_regs_test import ipr_pkg::*;;
  logic               sys_clk_in;
  logic               rstn_in;
  ipr_bus_req_s       bus_req;
  logic [DATA_W-1:0]  rd_data;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] en;
  ipr_grant_s         grant;
  ipr_levels_t        levels;
  logic [SRC_W-1:0]   cpu_src;
  logic [LVL_W-1:0]   cpu_lvl;
  logic [DATA_W-1:0]  word_exp [0:NUM_REG-1];
  int                 num_errors = 0;
  int                 checks_done = 0;
  int                 cycles = 0;

  ipr_regs i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .bus_req_in(bus_req), .rd_data_out(rd_data),
    .pending_flag_regs_in(pend), .source_enable_regs_in(en), .grant_out(grant), .levels_out(levels));
  ipr_cpu_model i_cpu (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .grant_in(grant),
    .taken_src_out(cpu_src), .taken_lvl_out(cpu_lvl));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge sys_clk_in);
    bus_req.wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe edge
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge sys_clk_in);
    bus_req.rd <= 1'b0;
    #1;
    check("read data", 32'(rd_data), 32'(exp));
  endtask

  // write then read back with no gap between the two strobes
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge sys_clk_in);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= d;
    @(posedge sys_clk_in);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk_in);
    bus_req.rd <= 1'b0;
    #1;
    check("readback data", 32'(rd_data), 32'(exp));
  endtask

  task automatic arb(input logic [NUM_SRC-1:0] p, input logic [NUM_SRC-1:0] e, input logic v,
                     input logic [4:0] s, input logic [2:0] l);
    @(posedge sys_clk_in);
    pend <= p;
    en <= e;
    @(posedge sys_clk_in);
    #1;
    check("grant valid", 32'(grant.valid), 32'(v));
    if (v) begin
      check("grant source", 32'(grant.source), 32'(s));
      check("grant level", 32'(grant.level), 32'(l));
    end
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // ceiling well above the hundred or so cycles the sequence needs
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    logic [15:0] pat;
    rstn_in = 1'b0;
    bus_req = '0;
    pend = '0;
    en = '0;
    repeat (4) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < NUM_REG; i++) rd_chk(REG_OFS[i], (i == 2) ? 16'h4404 : 16'h4444);
    for (int s = 0; s < NUM_SRC; s++) check("reset level", 32'(levels[s]), 32'(LEVEL_RESET));
    rd_chk(4'h5, 16'h0000);
    @(posedge sys_clk_in);
    #1;
    check("idle read data", 32'(rd_data), 32'h0);
    // back-to-back strobes: all ones in, the mask straight back
    for (int i = 0; i < NUM_REG; i++) wr_rd(REG_OFS[i], 16'hFFFF, REG_MASK[i]);
    rd_chk(PRIO11_OFS, 16'h7707);
    for (int i = 0; i < NUM_REG; i++) begin
      pat = {1'b1, 3'(i + 3), 1'b1, 3'(i + 2), 1'b1, 3'(i + 1), 1'b1, 3'(i)};
      word_exp[i] = pat & REG_MASK[i];
      wr(REG_OFS[i], pat);
    end
    // unmapped write must disturb nothing
    wr(4'hF, 16'hFFFF);
    for (int i = 0; i < NUM_REG; i++) rd_chk(REG_OFS[i], word_exp[i]);
    for (int s = 0; s < NUM_SRC; s++)
      check("level", 32'(levels[s]), 32'(word_exp[FIELD_REG[s]][FIELD_POS[s] +: 3]));
    // levels first, then flags and enables
    for (int i = 0; i < NUM_REG; i++) wr(REG_OFS[i], 16'h4444);
    arb('1, '1, 1'b1, 5'h00, 3'h4);
    wr(PRIO9_OFS, 16'h7444);
    arb('1, '1, 1'b1, SRC_CAPTURE5, LEVEL_MAX);
    check("core source", 32'(cpu_src), 32'(SRC_CAPTURE5));
    check("core level", 32'(cpu_lvl), 32'h7);
    arb('1, ~19'h00008, 1'b1, 5'h00, 3'h4);
    wr(PRIO9_OFS, 16'h7440);
    arb(19'h00001, 19'h00001, 1'b0, 5'h00, 3'h0);
    arb('1, ~19'h00008, 1'b1, SRC_CAPTURE3, 3'h4);
    wr_rd(PRIO13_OFS, 16'h4441, 16'h4441);
    arb(19'h08000, 19'h08000, 1'b1, SRC_TIMER9, LEVEL_MIN);
    arb(19'h18000, 19'h18000, 1'b1, SRC_EXT_IRQ3, 3'h4);
    arb('0, '1, 1'b0, 5'h00, 3'h0);
    @(posedge sys_clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    rd_chk(PRIO9_OFS, 16'h4444);
    rd_chk(PRIO13_OFS, 16'h4444);
    tally_and_finish();
  end
endmodule // ipr_regs_test
